// >>> core/oaie_operand_stage.sv
// Purpose: Operand fetch and effective address stage for 16-bit code words.
// Assumes: base_val holds the register named by the base field, sp_val the stack pointer.
// Notes:   All results appear one cycle after the code word, for one cycle.
module oaie_operand_stage (
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 instr_valid,
    input  wire oaie_pkg::oaie_code_t instr,
    input  wire oaie_pkg::oaie_word_t pc_val,
    input  wire oaie_pkg::oaie_word_t base_val,
    input  wire oaie_pkg::oaie_word_t sp_val,
    output logic                      op_valid_r,
    output logic [3:0]                op_code_r,
    output logic                      imm_valid_r,
    output oaie_pkg::oaie_word_t      imm_r,
    output logic                      mem_req_r,
    output logic                      mem_write_r,
    output oaie_pkg::oaie_size_t      mem_size_r,
    output oaie_pkg::oaie_word_t      mem_addr_r,
    output oaie_pkg::oaie_reg_t       mem_reg_r,
    output logic                      bit_op_r,
    output logic [1:0]                bit_kind_r,
    output logic [2:0]                bit_num_r,
    output logic                      addr_err_r,
    output logic                      base_wb_en_r,
    output oaie_pkg::oaie_reg_t       base_wb_idx_r,
    output oaie_pkg::oaie_word_t      base_wb_val_r,
    output logic                      branch_en_r,
    output logic [3:0]                branch_cond_r,
    output oaie_pkg::oaie_word_t      branch_target_r,
    output logic                      spr_xfer_r,
    output logic                      spr_to_special_r,
    output logic [1:0]                spr_sel_r,
    output oaie_pkg::oaie_reg_t       spr_gpr_r
);
    import oaie_pkg::*;

    oaie_pfx_if pfx ();

    oaie_prefix_acc u_prefix (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .instr_valid (instr_valid),
        .instr       (instr),
        .pfx         (pfx.keep)
    );

    function automatic oaie_word_t unsigned_imm(input logic [1:0] cnt, input oaie_pfx_t p1,
                                                input oaie_pfx_t p2, input logic [5:0] f);
        oaie_word_t v;
        v = {26'h0, f};
        if (cnt == OAIE_PFX_ONE) begin
            v = {13'h0, p1, f};
        end
        if (cnt == OAIE_PFX_TWO) begin
            v = {p1, p2, f};
        end
        return v;
    endfunction

    function automatic oaie_word_t signed_imm(input logic [1:0] cnt, input oaie_pfx_t p1,
                                              input oaie_pfx_t p2, input logic [5:0] f);
        oaie_word_t v;
        v = {{26{f[5]}}, f};
        if (cnt == OAIE_PFX_ONE) begin
            v = {{13{p1[12]}}, p1, f};
        end
        if (cnt == OAIE_PFX_TWO) begin
            v = {p1, p2, f};
        end
        return v;
    endfunction

    // Low bits of a prefixed stack displacement are forced aligned so that the
    // widened form can never produce a misaligned stack access.
    function automatic logic [5:0] aligned_low(input oaie_size_t sz, input logic [5:0] f);
        logic [5:0] v;
        v = f;
        if (sz == OAIE_SZ_HALF) begin
            v = {f[5:1], 1'b0};
        end else if (sz == OAIE_SZ_WORD) begin
            v = {f[5:2], 2'b00};
        end
        return v;
    endfunction

    function automatic oaie_word_t stack_disp(input logic [1:0] cnt, input oaie_pfx_t p1,
                                              input oaie_pfx_t p2, input oaie_size_t sz,
                                              input logic [5:0] f);
        oaie_word_t v;
        v = {26'h0, f};
        if (sz == OAIE_SZ_HALF) begin
            v = {25'h0, f, 1'b0};
        end else if (sz == OAIE_SZ_WORD) begin
            v = {24'h0, f, 2'b00};
        end
        if (cnt == OAIE_PFX_ONE) begin
            v = {13'h0, p1, aligned_low(sz, f)};
        end else if (cnt == OAIE_PFX_TWO) begin
            v = {p1, p2, aligned_low(sz, f)};
        end
        return v;
    endfunction

    function automatic oaie_word_t size_bytes(input oaie_size_t sz);
        oaie_word_t v;
        v = 32'h0000_0001;
        if (sz == OAIE_SZ_HALF) begin
            v = 32'h0000_0002;
        end else if (sz == OAIE_SZ_WORD) begin
            v = 32'h0000_0004;
        end
        return v;
    endfunction

    function automatic logic misaligned(input oaie_size_t sz, input oaie_word_t a);
        logic v;
        v = 1'b0;
        if (sz == OAIE_SZ_HALF) begin
            v = a[0];
        end else if (sz == OAIE_SZ_WORD) begin
            v = |a[1:0];
        end
        return v;
    endfunction

    logic [3:0]  op;
    logic [5:0]  fld;
    oaie_size_t  sz;
    logic [1:0]  cnt;
    oaie_word_t  disp;
    logic        is_prefix;
    logic        valid_nxt;
    logic        imm_valid_nxt;
    oaie_word_t  imm_nxt;
    logic        mem_req_nxt;
    logic        mem_write_nxt;
    oaie_size_t  mem_size_nxt;
    oaie_word_t  mem_addr_nxt;
    logic        bit_op_nxt;
    logic        err_nxt;
    logic        wb_en_nxt;
    oaie_word_t  wb_val_nxt;
    logic        br_en_nxt;
    oaie_word_t  br_target_nxt;
    logic        spr_nxt;

    assign op        = instr[OAIE_OP_MSB:OAIE_OP_LSB];
    assign fld       = instr[OAIE_FLD_MSB:OAIE_FLD_LSB];
    assign sz        = instr[OAIE_SIZE_MSB:OAIE_SIZE_LSB];
    assign cnt       = pfx.count;
    assign is_prefix = instr[OAIE_OP_MSB -: 3] == OAIE_PFX_TAG;

    assign pfx.take  = instr_valid && !is_prefix;

    always_comb begin
        valid_nxt     = instr_valid && !is_prefix;
        imm_valid_nxt = 1'b0;
        imm_nxt       = OAIE_WORD_RST;
        mem_req_nxt   = 1'b0;
        mem_write_nxt = 1'b0;
        mem_size_nxt  = OAIE_SZ_BYTE;
        mem_addr_nxt  = OAIE_WORD_RST;
        bit_op_nxt    = 1'b0;
        err_nxt       = 1'b0;
        wb_en_nxt     = 1'b0;
        wb_val_nxt    = OAIE_WORD_RST;
        br_en_nxt     = 1'b0;
        br_target_nxt = OAIE_WORD_RST;
        spr_nxt       = 1'b0;
        disp          = OAIE_WORD_RST;
        if (valid_nxt) begin
            // only listed forms read the prefix
            case (op)
                OAIE_OP_ADDI, OAIE_OP_SUBI: begin
                    imm_valid_nxt = 1'b1;
                    imm_nxt       = unsigned_imm(cnt, pfx.first, pfx.second, fld);
                end
                OAIE_OP_ANDI, OAIE_OP_ORI, OAIE_OP_XORI, OAIE_OP_NOTI, OAIE_OP_CMPI,
                OAIE_OP_LDI: begin
                    imm_valid_nxt = 1'b1;
                    imm_nxt       = signed_imm(cnt, pfx.first, pfx.second, fld);
                end
                OAIE_OP_SHI: begin
                    imm_valid_nxt = 1'b1;
                    imm_nxt       = {28'h0, instr[OAIE_CNT_MSB:OAIE_CNT_LSB]};
                end
                OAIE_OP_IND: begin
                    mem_req_nxt   = 1'b1;
                    mem_write_nxt = instr[OAIE_STORE_BIT];
                    mem_size_nxt  = sz;
                    if (instr[OAIE_PINC_BIT]) begin
                        mem_addr_nxt = base_val;
                        wb_en_nxt    = 1'b1;
                        wb_val_nxt   = base_val + size_bytes(sz);
                    end else begin
                        if (cnt == OAIE_PFX_ONE) begin
                            disp = {19'h0, pfx.first};
                        end else if (cnt == OAIE_PFX_TWO) begin
                            disp = {6'h0, pfx.first, pfx.second};
                        end
                        mem_addr_nxt = base_val + disp;
                    end
                    err_nxt = misaligned(sz, mem_addr_nxt);
                end
                OAIE_OP_SPLD, OAIE_OP_SPST: begin
                    mem_req_nxt   = 1'b1;
                    mem_write_nxt = op == OAIE_OP_SPST;
                    mem_size_nxt  = sz;
                    mem_addr_nxt  = sp_val + stack_disp(cnt, pfx.first, pfx.second, sz, fld);
                    err_nxt       = misaligned(sz, mem_addr_nxt);
                end
                OAIE_OP_BR: begin
                    br_en_nxt = 1'b1;
                    disp = {{23{instr[OAIE_BROFF_MSB]}}, instr[OAIE_BROFF_MSB:0], 1'b0};
                    if (cnt == OAIE_PFX_ONE) begin
                        disp = {{10{pfx.first[12]}}, pfx.first, instr[OAIE_BROFF_MSB:0], 1'b0};
                    end else if (cnt == OAIE_PFX_TWO) begin
                        disp = {pfx.first, pfx.second, instr[OAIE_BROFF_MSB:3], 1'b0};
                    end
                    br_target_nxt = pc_val + disp;
                end
                OAIE_OP_MISC: begin
                    if (instr[OAIE_GRP_MSB:OAIE_GRP_LSB] == OAIE_GRP_BIT) begin
                        // Bit operations act on one byte, so they never fault.
                        mem_req_nxt  = 1'b1;
                        bit_op_nxt   = 1'b1;
                        if (cnt == OAIE_PFX_ONE) begin
                            disp = {19'h0, pfx.first};
                        end else if (cnt == OAIE_PFX_TWO) begin
                            disp = {6'h0, pfx.first, pfx.second};
                        end
                        mem_addr_nxt = base_val + disp;
                    end else if (instr[OAIE_GRP_MSB:OAIE_GRP_LSB] == OAIE_GRP_SPR) begin
                        spr_nxt = 1'b1;
                    end
                end
                default: begin
                    valid_nxt = 1'b1;
                end
            endcase
        end
        if (err_nxt) begin
            mem_req_nxt = 1'b0;
            wb_en_nxt   = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            op_valid_r  <= 1'b0;
            op_code_r   <= 4'h0;
            imm_valid_r <= 1'b0;
            imm_r       <= OAIE_WORD_RST;
        end else begin
            op_valid_r  <= valid_nxt;
            op_code_r   <= op;
            imm_valid_r <= imm_valid_nxt;
            imm_r       <= imm_nxt;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mem_req_r   <= 1'b0;
            mem_write_r <= 1'b0;
            mem_size_r  <= OAIE_SZ_BYTE;
            mem_addr_r  <= OAIE_WORD_RST;
            mem_reg_r   <= 4'h0;
            bit_op_r    <= 1'b0;
            bit_kind_r  <= 2'h0;
            bit_num_r   <= 3'h0;
            addr_err_r  <= 1'b0;
        end else begin
            mem_req_r   <= mem_req_nxt;
            mem_write_r <= mem_write_nxt;
            mem_size_r  <= mem_size_nxt;
            mem_addr_r  <= mem_addr_nxt;
            mem_reg_r   <= instr[OAIE_RD_MSB:OAIE_RD_LSB];
            bit_op_r    <= bit_op_nxt;
            bit_kind_r  <= instr[OAIE_BOP_MSB:OAIE_BOP_LSB];
            bit_num_r   <= instr[OAIE_BITN_MSB:OAIE_BITN_LSB];
            addr_err_r  <= err_nxt;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            base_wb_en_r  <= 1'b0;
            base_wb_idx_r <= 4'h0;
            base_wb_val_r <= OAIE_WORD_RST;
        end else begin
            base_wb_en_r  <= wb_en_nxt;
            base_wb_idx_r <= instr[OAIE_RB_MSB:OAIE_RB_LSB];
            base_wb_val_r <= wb_val_nxt;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            branch_en_r     <= 1'b0;
            branch_cond_r   <= 4'h0;
            branch_target_r <= OAIE_WORD_RST;
        end else begin
            branch_en_r     <= br_en_nxt;
            branch_cond_r   <= instr[OAIE_SIZE_MSB:OAIE_SIZE_LSB - 2];
            branch_target_r <= br_target_nxt;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            spr_xfer_r       <= 1'b0;
            spr_to_special_r <= 1'b0;
            spr_sel_r        <= OAIE_SPR_PSR;
            spr_gpr_r        <= 4'h0;
        end else begin
            spr_xfer_r       <= spr_nxt;
            spr_to_special_r <= instr[OAIE_SDIR_BIT];
            spr_sel_r        <= instr[OAIE_SSEL_MSB:OAIE_SSEL_LSB];
            spr_gpr_r        <= instr[OAIE_RD_MSB:OAIE_RD_LSB];
        end
    end
endmodule

// >>> core/oaie_pkg.sv
// Purpose: Shared encodings, field positions and reset values of the operand stage.
// Assumes: One 16-bit code word per cycle from fetch; register values arrive with it.
// Notes:   The code word layout below is the decoder's own packed form.
package oaie_pkg;
    typedef logic [31:0] oaie_word_t;
    typedef logic [15:0] oaie_code_t;
    typedef logic [12:0] oaie_pfx_t;
    typedef logic [1:0]  oaie_size_t;
    typedef logic [3:0]  oaie_reg_t;

    localparam int OAIE_OP_MSB    = 15;
    localparam int OAIE_OP_LSB    = 12;
    localparam int OAIE_PFX_MSB   = 12;
    localparam int OAIE_SIZE_MSB  = 11;
    localparam int OAIE_SIZE_LSB  = 10;
    localparam int OAIE_FLD_MSB   = 9;
    localparam int OAIE_FLD_LSB   = 4;
    localparam int OAIE_STORE_BIT = 9;
    localparam int OAIE_PINC_BIT  = 8;
    localparam int OAIE_RB_MSB    = 7;
    localparam int OAIE_RB_LSB    = 4;
    localparam int OAIE_RD_MSB    = 3;
    localparam int OAIE_RD_LSB    = 0;
    localparam int OAIE_CNT_MSB   = 7;
    localparam int OAIE_CNT_LSB   = 4;
    localparam int OAIE_BROFF_MSB = 7;
    localparam int OAIE_GRP_MSB   = 11;
    localparam int OAIE_GRP_LSB   = 10;
    localparam int OAIE_BOP_MSB   = 9;
    localparam int OAIE_BOP_LSB   = 8;
    localparam int OAIE_BITN_MSB  = 6;
    localparam int OAIE_BITN_LSB  = 4;
    localparam int OAIE_SDIR_BIT  = 9;
    localparam int OAIE_SSEL_MSB  = 5;
    localparam int OAIE_SSEL_LSB  = 4;

    localparam logic [2:0] OAIE_PFX_TAG = 3'h6;
    localparam logic [3:0] OAIE_OP_ADDI = 4'h0;
    localparam logic [3:0] OAIE_OP_SUBI = 4'h1;
    localparam logic [3:0] OAIE_OP_ANDI = 4'h2;
    localparam logic [3:0] OAIE_OP_ORI  = 4'h3;
    localparam logic [3:0] OAIE_OP_XORI = 4'h4;
    localparam logic [3:0] OAIE_OP_NOTI = 4'h5;
    localparam logic [3:0] OAIE_OP_CMPI = 4'h6;
    localparam logic [3:0] OAIE_OP_LDI  = 4'h7;
    localparam logic [3:0] OAIE_OP_SHI  = 4'h8;
    localparam logic [3:0] OAIE_OP_IND  = 4'h9;
    localparam logic [3:0] OAIE_OP_SPLD = 4'ha;
    localparam logic [3:0] OAIE_OP_SPST = 4'hb;
    localparam logic [3:0] OAIE_OP_BR   = 4'he;
    localparam logic [3:0] OAIE_OP_MISC = 4'hf;

    localparam logic [1:0] OAIE_GRP_BIT = 2'h0;
    localparam logic [1:0] OAIE_GRP_SPR = 2'h1;

    localparam oaie_size_t OAIE_SZ_BYTE = 2'h0;
    localparam oaie_size_t OAIE_SZ_HALF = 2'h1;
    localparam oaie_size_t OAIE_SZ_WORD = 2'h2;

    localparam logic [1:0] OAIE_SPR_PSR = 2'h0;
    localparam logic [1:0] OAIE_SPR_SP  = 2'h1;
    localparam logic [1:0] OAIE_SPR_ALR = 2'h2;
    localparam logic [1:0] OAIE_SPR_AHR = 2'h3;

    localparam logic [1:0] OAIE_PFX_NONE = 2'h0;
    localparam logic [1:0] OAIE_PFX_ONE  = 2'h1;
    localparam logic [1:0] OAIE_PFX_TWO  = 2'h2;

    localparam oaie_word_t OAIE_WORD_RST = 32'h0000_0000;
    localparam oaie_pfx_t  OAIE_PFX_RST  = 13'h0000;
endpackage

// >>> core/oaie_pfx_if.sv
// Purpose: Carries pending prefix state from the accumulator to the decoder.
// Assumes: One clock domain.
// Notes:   The decoder pulses take on every non-prefix instruction it accepts.
interface oaie_pfx_if;
    logic [1:0]         count;
    oaie_pkg::oaie_pfx_t first;
    oaie_pkg::oaie_pfx_t second;
    logic               take;

    modport keep (output count, output first, output second, input take);
    modport dec  (input count, input first, input second, output take);
endinterface

// >>> core/oaie_prefix_acc.sv
// Purpose: Holds the prefix immediates that widen the next instruction.
// Assumes: Code words arrive one per cycle with instr_valid.
// Notes:   A run of prefixes keeps the first and overwrites the second slot.
module oaie_prefix_acc (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             instr_valid,
    input  wire oaie_pkg::oaie_code_t instr,
    oaie_pfx_if.keep              pfx
);
    import oaie_pkg::*;

    logic is_prefix;

    assign is_prefix = instr_valid && (instr[OAIE_OP_MSB -: 3] == OAIE_PFX_TAG);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pfx.count  <= OAIE_PFX_NONE;
            pfx.first  <= OAIE_PFX_RST;
            pfx.second <= OAIE_PFX_RST;
        end else if (is_prefix) begin
            if (pfx.count == OAIE_PFX_NONE) begin
                pfx.first <= instr[OAIE_PFX_MSB:0];
                pfx.count <= OAIE_PFX_ONE;
            end else begin
                pfx.second <= instr[OAIE_PFX_MSB:0];
                pfx.count  <= OAIE_PFX_TWO;
            end
        end else if (pfx.take) begin
            pfx.count <= OAIE_PFX_NONE;
        end
    end
endmodule

// >>> dv/oaie_regs_model.sv
// Purpose: Register file stand-in that feeds base and stack values to the stage.
// Assumes: Writebacks land on the edge after the stage reports them.
// Notes:   Reads are combinational, as a register file read port would be.
module oaie_regs_model (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [15:0] instr,
    input  wire logic        wb_en,
    input  wire logic [3:0]  wb_idx,
    input  wire logic [31:0] wb_val,
    output logic [31:0]      base_val,
    output logic [31:0]      sp_val
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] regs [16];
    // Register n starts at (n+1)*0x100 so every base is predictable.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int n = 0; n < 16; n++) regs[n] <= 32'(n + 1) << 8;
        end else if (wb_en) begin
            regs[wb_idx] <= wb_val;
        end
    end
    assign base_val = regs[instr[7:4]];
    assign sp_val   = 32'h0000_8000;
endmodule

// >>> dv/oaie_operand_stage_asserts.sv
// Purpose: Bound checks on the operand stage ports.
// Assumes: Each result follows its code word by exactly one cycle.
// Notes:   Pending prefix state is rebuilt here from the code words.
module oaie_chk (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        instr_valid,
    input wire logic [15:0] instr,
    input wire logic [31:0] base_val,
    input wire logic [31:0] sp_val,
    input wire logic        op_valid_r,
    input wire logic [31:0] imm_r,
    input wire logic        mem_req_r,
    input wire logic [1:0]  mem_size_r,
    input wire logic [31:0] mem_addr_r,
    input wire logic        addr_err_r,
    input wire logic        base_wb_en_r,
    input wire logic [31:0] base_wb_val_r
);
    timeunit 1ns;
    timeprecision 1ps;
    import oaie_pkg::*;
    logic       pend_r;
    logic       pfx;
    logic [3:0] op;
    logic       go;
    assign pfx = instr[15:13] == OAIE_PFX_TAG;
    assign op  = instr[15:12];
    assign go  = instr_valid && !pfx && !pend_r;
    // A prefix stays pending across idle cycles until a non-prefix word is taken.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pend_r <= 1'b0;
        end else if (instr_valid) begin
            pend_r <= pfx;
        end
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    pfx_silent_a: assert property (instr_valid && pfx |=> !op_valid_r)
        else $error("prefix word decoded");
    misalign_err_a: assert property (go && op == OAIE_OP_IND &&
        instr[11:10] == OAIE_SZ_WORD && base_val[1:0] != 2'h0 |=> addr_err_r && !mem_req_r)
        else $error("misaligned word not faulted");
    fault_block_a: assert property (addr_err_r |-> !mem_req_r && !base_wb_en_r)
        else $error("faulted access still issued");
    wb_with_req_a: assert property (base_wb_en_r |-> mem_req_r)
        else $error("writeback without access");
    postinc_step_a: assert property (base_wb_en_r |->
        base_wb_val_r == mem_addr_r + (32'h1 << mem_size_r))
        else $error("post-increment step wrong");
    stack_addr_a: assert property (go && (op == OAIE_OP_SPLD || op == OAIE_OP_SPST) |=>
        mem_addr_r == $past(sp_val) + (32'($past(instr[9:4])) << $past(instr[11:10])))
        else $error("stack address wrong");
    ind_addr_a: assert property (instr_valid && op == OAIE_OP_IND &&
        (instr[8] || !pend_r) |=> mem_addr_r == $past(base_val))
        else $error("indirect address wrong");
    shift_cnt_a: assert property (instr_valid && op == OAIE_OP_SHI |=>
        imm_r == {28'h0, $past(instr[7:4])})
        else $error("shift count widened");
    c_fault: cover property (addr_err_r);
    c_pinc: cover property (base_wb_en_r);
    c_run3: cover property (instr_valid && pfx ##1 instr_valid && pfx ##1 instr_valid && pfx);
endmodule
bind oaie_operand_stage oaie_chk u_chk (.clock, .sys_rst, .instr_valid, .instr, .base_val,
    .sp_val, .op_valid_r, .imm_r, .mem_req_r, .mem_size_r, .mem_addr_r, .addr_err_r,
    .base_wb_en_r, .base_wb_val_r);

// >>> dv/tb_oaie_operand_stage.sv
// Purpose: Directed checks of operand widening and address forming.
// Assumes: Register n holds (n+1)*0x100 after reset, the stack pointer 0x8000.
// Notes:   One code word or prefix run is in flight at a time to keep timing plain.
module tb_oaie_operand_stage;
    timeunit 1ns;
    timeprecision 1ps;
    import oaie_pkg::*;
    localparam logic [12:0] Z = 13'h0;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        instr_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [31:0] base_val, sp_val, imm_r, mem_addr_r, base_wb_val_r, branch_target_r;
    logic [31:0] pc_val = 32'h0000_1000;
    logic [3:0]  base_wb_idx_r, op_code_r, mem_reg_r, branch_cond_r, spr_gpr_r;
    logic [1:0]  mem_size_r, spr_sel_r, bit_kind_r;
    logic [2:0]  bit_num_r;
    logic        op_valid_r, mem_req_r, mem_write_r, addr_err_r, base_wb_en_r;
    logic        branch_en_r, spr_xfer_r, bit_op_r, imm_valid_r, spr_to_special_r;
    int          miscompares = 0;
    int          checks = 0;
    always #2.5 clock = ~clock;
    oaie_operand_stage dut (.clock, .sys_rst, .instr_valid, .instr,
        .pc_val, .base_val, .sp_val, .op_valid_r, .op_code_r,
        .imm_valid_r, .imm_r, .mem_req_r, .mem_write_r, .mem_size_r, .mem_addr_r,
        .mem_reg_r, .bit_op_r, .bit_kind_r, .bit_num_r, .addr_err_r,
        .base_wb_en_r, .base_wb_idx_r, .base_wb_val_r, .branch_en_r, .branch_cond_r,
        .branch_target_r, .spr_xfer_r, .spr_to_special_r, .spr_sel_r, .spr_gpr_r);
    oaie_regs_model regs (.clock, .sys_rst, .instr, .wb_en(base_wb_en_r),
        .wb_idx(base_wb_idx_r), .wb_val(base_wb_val_r), .base_val, .sp_val);
    task automatic chk(input string n, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    function automatic logic [15:0] w(logic [3:0] op, logic [1:0] sz, logic [5:0] f);
        return {op, sz, f, 4'h1};
    endfunction
    // Middle prefixes of a long run carry a filler value that must vanish.
    task automatic run(input int n, input logic [12:0] p1, p2, input logic [15:0] c);
        for (int i = 0; i < n + 1; i++) begin
            @(posedge clock);
            instr_valid <= 1'b1;
            instr <= (i == n) ? c : {3'h6, (i == 0) ? p1 : (i == n - 1) ? p2 : 13'h0aaa};
        end
        @(posedge clock);
        instr_valid <= 1'b0;
        @(negedge clock);
    endtask
    task automatic t_imm();
        run(0, Z, Z, 16'hc001);
        chk("opv", op_valid_r, 32'h0);
        run(0, Z, Z, w(OAIE_OP_ADDI, 2'h0, 6'h15));
        chk("add1", imm_r, {13'h0, 13'h1, 6'h15});
        chk("imv", imm_valid_r, 32'h1);
        chk("opc", op_code_r, 32'(OAIE_OP_ADDI));
        run(2, 13'h1fff, 13'h0001, w(OAIE_OP_SUBI, 2'h0, 6'h2a));
        chk("sub2", imm_r, {13'h1fff, 13'h0001, 6'h2a});
        for (int o = 2; o < 8; o++) begin
            run(1, 13'h1abc, Z, w(4'(o), 2'h0, 6'h05));
            chk("sx19", imm_r, {13'h1fff, 13'h1abc, 6'h05});
        end
        run(2, 13'h1000, Z, w(OAIE_OP_CMPI, 2'h0, 6'h3f));
        chk("sx32", imm_r, {13'h1000, 13'h0, 6'h3f});
        run(3, 13'h1, 13'h2, w(OAIE_OP_ADDI, 2'h0, 6'h00));
        chk("run3", imm_r, {13'h1, 13'h2, 6'h0});
        run(2, 13'h1fff, 13'h1fff, w(OAIE_OP_SHI, 2'h0, 6'h05));
        chk("shc", imm_r, 32'h5);
        run(0, Z, Z, w(OAIE_OP_LDI, 2'h0, 6'h20));
        chk("sx6", imm_r, 32'hffff_ffe0);
        $display("t_imm done");
    endtask
    task automatic t_ind();
        run(0, Z, Z, w(OAIE_OP_IND, OAIE_SZ_WORD, 6'h02));
        chk("ia", mem_addr_r, 32'h300);
        chk("isz", mem_size_r, 32'(OAIE_SZ_WORD));
        chk("ird", mem_reg_r, 32'h1);
        run(1, 13'h3, Z, w(OAIE_OP_IND, OAIE_SZ_HALF, 6'h00));
        chk("da", mem_addr_r, 32'h103);
        chk("derr", addr_err_r, 32'h1);
        chk("dreq", mem_req_r, 32'h0);
        run(2, 13'h1, Z, w(OAIE_OP_IND, OAIE_SZ_WORD, 6'h23));
        chk("d2a", mem_addr_r, 32'h2400);
        chk("d2w", mem_write_r, 32'h1);
        run(1, 13'h4, Z, w(OAIE_OP_MISC, OAIE_GRP_BIT, 6'h33));
        chk("ba", mem_addr_r, 32'h404);
        chk("bop", bit_op_r, 32'h1);
        chk("bk", bit_kind_r, 32'h3);
        chk("bn", bit_num_r, 32'h3);
        $display("t_ind done");
    endtask
    task automatic t_pinc();
        run(1, 13'h10, Z, w(OAIE_OP_IND, OAIE_SZ_WORD, 6'h15));
        chk("pa", mem_addr_r, 32'h600);
        chk("pwv", base_wb_val_r, 32'h604);
        chk("pwi", base_wb_idx_r, 32'h5);
        run(0, Z, Z, w(OAIE_OP_IND, OAIE_SZ_BYTE, 6'h15));
        chk("pb", base_wb_val_r, 32'h605);
        run(0, Z, Z, w(OAIE_OP_IND, OAIE_SZ_HALF, 6'h15));
        chk("pfe", base_wb_en_r, 32'h0);
        chk("pfr", addr_err_r, 32'h1);
        run(0, Z, Z, w(OAIE_OP_IND, OAIE_SZ_BYTE, 6'h15));
        chk("pkeep", mem_addr_r, 32'h605);
        // Base now 0x606: an unprefixed word access must fault.
        run(0, Z, Z, w(OAIE_OP_IND, OAIE_SZ_WORD, 6'h15));
        chk("pwe", addr_err_r, 32'h1);
        chk("pwn", base_wb_en_r, 32'h0);
        run(0, Z, Z, w(OAIE_OP_IND, OAIE_SZ_HALF, 6'h16));
        chk("ph", base_wb_val_r, 32'h702);
        $display("t_pinc done");
    endtask
    task automatic t_stack();
        for (int s = 0; s < 3; s++) begin
            run(0, Z, Z, w(OAIE_OP_SPLD, 2'(s), 6'h3f));
            chk("sa", mem_addr_r, 32'h8000 + (32'h3f << s));
        end
        run(1, 13'h1, Z, w(OAIE_OP_SPST, OAIE_SZ_HALF, 6'h3f));
        chk("s1", mem_addr_r, 32'h8000 + {13'h0, 13'h1, 5'h1f, 1'b0});
        chk("sw", mem_write_r, 32'h1);
        run(2, Z, 13'h1, w(OAIE_OP_SPLD, OAIE_SZ_WORD, 6'h3f));
        chk("s2", mem_addr_r, 32'h8000 + {13'h0, 13'h1, 4'hf, 2'h0});
        $display("t_stack done");
    endtask
    task automatic t_misc();
        run(0, Z, Z, 16'he3fe);
        chk("b0", branch_target_r, 32'h0000_0ffc);
        chk("be", branch_en_r, 32'h1);
        chk("bc", branch_cond_r, 32'h3);
        @(posedge clock) pc_val <= 32'h0002_0000;
        run(1, 13'h1, Z, 16'he300);
        chk("b1", branch_target_r, 32'h0002_0200);
        for (int s = 0; s < 4; s++) begin
            run(1, 13'h1fff, Z, w(OAIE_OP_MISC, OAIE_GRP_SPR, 6'(s * 17)));
            chk("spr", spr_sel_r, 32'(s));
            chk("spd", spr_to_special_r, 32'(s > 1));
            chk("spg", spr_gpr_r, 32'h1);
            chk("spx", spr_xfer_r, 32'h1);
        end
        run(0, Z, Z, w(OAIE_OP_ADDI, 2'h0, 6'h03));
        chk("clr", imm_r, 32'h3);
        $display("t_misc done");
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        t_imm();
        t_ind();
        t_pinc();
        t_stack();
        t_misc();
        print_verdict();
    end
    initial begin
        repeat (4000) @(posedge clock);
        miscompares++;
        print_verdict();
    end
endmodule
